// ---- bench/host_serial_model.sv ----
// host controller model driving the serial control port
`timescale 1ns/1ns
module host_serial_model #(
    parameter bit QUENCH_OK = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic sdo,
    input  wire logic line_rev_e_ok,
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi
);
    localparam int HALF = 3;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one 24 bit frame, msb first; sel_n high leaves the port deselected
    task automatic frame(input logic sel_n, input logic [23:0] bits,
                         output logic [7:0] got);
        got = 8'h00;
        @(posedge sys_clk);
        cs_n <= sel_n;
        tick(2);
        for (int i = 23; i >= 0; i--) begin
            sclk <= 1'b0;
            sdi  <= bits[i];
            tick(HALF);
            if (i < 8) begin
                got = {got[6:0], sdo};
            end
            sclk <= 1'b1;
            tick(HALF);
        end
        sclk <= 1'b0;
        tick(HALF);
        cs_n <= 1'b1;
        sdi  <= ~sdi;
        tick(2);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        logic [7:0] unused;
        d = data & hook_gain_pkg::SQG_WR_MASK;
        if (!QUENCH_OK) begin
            d[6] = 1'b0;
            d[4] = 1'b0;
        end
        if (!line_rev_e_ok) begin
            d[2:1] = 2'b00;
        end
        frame(1'b0, {8'h00, addr, d}, unused);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        frame(1'b0, {8'h20, addr, 8'h00}, data);
    endtask

    // full write frame clocked while deselected
    task automatic ghost();
        logic [7:0] unused;
        frame(1'b1, {8'h00, hook_gain_pkg::SQG_ADDR, 8'h56}, unused);
    endtask
endmodule

// ---- bench/tb_hook_release_gain_control.sv ----
// self-checking testbench for the hook release and gain control block
`timescale 1ns/1ns
module tb_hook_release_gain_control;
    localparam logic [17:0] MID_N  = 18'h0000A;
    localparam logic [17:0] SLOW_N = 18'h00014;
    localparam logic [7:0]  ADDR   = hook_gain_pkg::SQG_ADDR;

    logic       sys_clk, resetn, cs_n, sclk, sdi, sdo, sdo_oe_n, sdi_thru;
    logic       offhook, spd, spd_b, line_cur, rev_e, sleep_req;
    logic       ring_rect, spk_pwm, irq_req, irq_mode;
    logic       loop_on, rx_boost, guard, sleeping, ring_n, shared_out;
    logic [1:0] quench;
    logic [7:0] rv;
    logic       sdo_line;
    int         err_count;
    int         tests_run;

    // released sdo shows the inverse of its last value
    assign sdo_line = sdo_oe_n ? ~sdo : sdo;

    host_serial_model host_u (.sys_clk(sys_clk), .sdo(sdo_line),
        .line_rev_e_ok(rev_e), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

    hook_release_gain_control #(.MID_CYC(MID_N), .SLOW_CYC(SLOW_N)) dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .serial_in_passthrough(sdi_thru), .offhook_ctrl(offhook),
        .onhook_speed_sel(spd), .onhook_speed_sel_b(spd_b),
        .line_current_sel_bit(line_cur), .line_rev_e_ok(rev_e),
        .sleep_req(sleep_req), .ring_rect(ring_rect), .spk_pwm(spk_pwm),
        .irq_req(irq_req), .irq_mode_sel(irq_mode),
        .loop_current_on(loop_on), .spark_quench_code(quench),
        .rx_gain_boost(rx_boost), .guard_draw_en(guard),
        .sleeping(sleeping), .ring_detect_out_n(ring_n),
        .speaker_or_irq_out(shared_out));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_reset();
        check(8'(sdo_oe_n), 8'h01);
        check(8'(ring_n), 8'h01);
        check({loop_on, quench, rx_boost, guard, sleeping, 2'b00}, 8'h00);
        host_u.rd(ADDR, rv);
        check(rv, hook_gain_pkg::SQG_RESET);
        $display("reset test done");
    endtask

    task automatic t_write();
        host_u.wr(ADDR, 8'h54);
        cyc(3);
        check(8'(quench), 8'h03);
        check(8'(rx_boost), 8'h01);
        host_u.rd(ADDR, rv);
        check(rv, 8'h54);
        @(posedge sys_clk);
        rev_e <= 1'b0;
        cyc(2);
        check(8'(rx_boost), 8'h00);
        @(posedge sys_clk);
        rev_e <= 1'b1;
        host_u.wr(8'h3A, 8'h02);
        host_u.rd(ADDR, rv);
        check(rv, 8'h54);
        host_u.rd(8'h3A, rv);
        check(rv, 8'h00);
        $display("write test done");
    endtask

    task automatic t_guard();
        host_u.wr(ADDR, 8'h02);
        @(posedge sys_clk);
        line_cur <= 1'b1;
        cyc(2);
        check(8'(guard), 8'h01);
        check(8'(rx_boost), 8'h00);
        @(posedge sys_clk);
        line_cur <= 1'b0;
        cyc(2);
        check(8'(guard), 8'h00);
        $display("guard test done");
    endtask

    task automatic t_gate();
        host_u.ghost();
        cyc(1);
        check(8'(sdo_oe_n), 8'h01);
        check(8'(sdi_thru), 8'(sdi));
        host_u.rd(ADDR, rv);
        check(rv, 8'h02);
        $display("chip select test done");
    endtask

    task automatic rel(input logic [1:0] sel, input logic [7:0] rg,
                       input int n);
        int k;
        host_u.wr(ADDR, rg);
        @(posedge sys_clk);
        offhook <= 1'b1;
        spd     <= sel[1];
        spd_b   <= sel[0];
        cyc(2);
        check(8'(loop_on), 8'h01);
        @(posedge sys_clk);
        offhook <= 1'b0;
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (loop_on === 1'b1 && k < 100);
        check(8'(k), 8'(n + 1));
        $display("release test done");
    endtask

    task automatic t_abort();
        int drops;
        drops = 0;
        @(posedge sys_clk);
        offhook <= 1'b1;
        cyc(2);
        @(posedge sys_clk);
        offhook <= 1'b0;
        cyc(4);
        @(posedge sys_clk);
        offhook <= 1'b1;
        repeat (30) begin
            cyc(1);
            if (loop_on !== 1'b1) begin
                drops++;
            end
        end
        check(8'(drops), 8'h00);
        check(8'(loop_on), 8'h01);
        $display("abort test done");
    endtask

    task automatic t_pins();
        @(posedge sys_clk);
        ring_rect <= 1'b1;
        irq_mode  <= 1'b1;
        irq_req   <= 1'b1;
        cyc(2);
        check(8'(ring_n), 8'h00);
        check(8'(shared_out), 8'h00);
        @(posedge sys_clk);
        irq_req   <= 1'b0;
        ring_rect <= 1'b0;
        cyc(2);
        check(8'(ring_n), 8'h01);
        check(8'(shared_out), 8'h01);
        @(posedge sys_clk);
        irq_mode <= 1'b0;
        spk_pwm  <= 1'b0;
        cyc(2);
        check(8'(shared_out), 8'h00);
        $display("pin test done");
    endtask

    task automatic t_sleep();
        @(posedge sys_clk);
        sleep_req <= 1'b1;
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        cyc(3);
        check(8'(sleeping), 8'h01);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        cyc(1);
        check(8'(sleeping), 8'h00);
        host_u.rd(ADDR, rv);
        check(rv, 8'h00);
        $display("sleep test done");
    endtask

    initial begin
        err_count = 0;
        tests_run = 0;
        resetn = 1'b0;
        {offhook, spd, spd_b, line_cur, sleep_req} = 5'b00000;
        {ring_rect, irq_req, irq_mode} = 3'b000;
        spk_pwm = 1'b1;
        rev_e = 1'b1;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        cyc(1);
        t_reset();
        t_write();
        t_guard();
        t_gate();
        rel(2'b00, 8'h00, 1);
        rel(2'b01, 8'h00, int'(MID_N));
        rel(2'b10, 8'h50, int'(SLOW_N));
        t_abort();
        t_pins();
        t_sleep();
        results();
    end
endmodule

// ---- core/hook_gain_pkg.sv ----
// constants and types shared by the hook release and gain control block
package hook_gain_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] SQG_ADDR    = 8'h3B;
    localparam logic [7:0] SQG_RESET   = 8'h00;
    localparam logic [7:0] SQG_WR_MASK = 8'h56;
    localparam int         SQ_HI_BIT   = 6;
    localparam int         SQ_LO_BIT   = 4;
    localparam int         RXG_BIT     = 2;
    localparam int         GUARD_BIT   = 1;

    // ****************************************
    // serial frame layout
    // ****************************************
    localparam int         CMD_RD_BIT  = 5;
    localparam logic [4:0] CMD_END     = 5'h07;
    localparam logic [4:0] ADDR_END    = 5'h0F;
    localparam logic [4:0] DATA_END    = 5'h17;

    // ****************************************
    // on-hook release timing
    // ****************************************
    localparam int         CLK_PERIOD_NS = 100;
    localparam int         FAST_MAX_NS   = 500000;
    localparam int         FAST_CYC      = 1;
    localparam int         MID_NS        = 3000000;
    localparam int         MID_CYC       = MID_NS / CLK_PERIOD_NS;
    localparam int         SLOW_NS       = 26000000;
    localparam int         SLOW_CYC      = SLOW_NS / CLK_PERIOD_NS;
    localparam int         HOLD_W        = 18;

    // ****************************************
    // state types
    // ****************************************
    typedef enum logic [2:0] {
        XF_IDLE  = 3'b001,
        XF_SHIFT = 3'b010,
        XF_DONE  = 3'b100
    } xfer_state_t;

    typedef enum logic [2:0] {
        HK_ONHOOK  = 3'b001,
        HK_OFFHOOK = 3'b010,
        HK_RELEASE = 3'b100
    } hook_state_t;

endpackage

// ---- core/hook_release_gain_control.sv ----
// spark quench and gain register bank with hook release timing
`timescale 1ns/1ns
module hook_release_gain_control #(
    parameter logic [17:0] MID_CYC  = 18'(hook_gain_pkg::MID_CYC),
    parameter logic [17:0] SLOW_CYC = 18'(hook_gain_pkg::SLOW_CYC)
) (
    input  wire logic  sys_clk,
    input  wire logic  resetn,
    input  wire logic  cs_n,
    input  wire logic  sclk,
    input  wire logic  sdi,
    output logic       sdo,
    output logic       sdo_oe_n,
    output logic       serial_in_passthrough,
    input  wire logic  offhook_ctrl,
    input  wire logic  onhook_speed_sel,
    input  wire logic  onhook_speed_sel_b,
    input  wire logic  line_current_sel_bit,
    input  wire logic  line_rev_e_ok,
    input  wire logic  sleep_req,
    input  wire logic  ring_rect,
    input  wire logic  spk_pwm,
    input  wire logic  irq_req,
    input  wire logic  irq_mode_sel,
    output logic       loop_current_on,
    output logic [1:0] spark_quench_code,
    output logic       rx_gain_boost,
    output logic       guard_draw_en,
    output logic       sleeping,
    output logic       ring_detect_out_n,
    output logic       speaker_or_irq_out
);
    spi_xfer_if xf ();

    hook_gain_pkg::hook_state_t hk_state_r, hk_state_nxt;
    logic [7:0]  sqg_r, sqg_nxt;
    logic [17:0] hold_cnt_r, hold_cnt_nxt;
    logic        loop_on_r, loop_on_nxt;
    logic [1:0]  sq_code_r, sq_code_nxt;
    logic        rxg_r, rxg_nxt;
    logic        guard_r, guard_nxt;
    logic        sleep_r, sleep_nxt;
    logic        ring_n_r, ring_n_nxt;
    logic        spk_r, spk_nxt;
    logic        spark_quench_sel_hi;
    logic        spark_quench_sel_lo;
    logic        guarded_clear_en;
    logic [17:0] rel_len;
    logic        sel_fast;

    // ****************************************
    // serial port
    // ****************************************
    serial_port_engine u_engine (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .cs_n     (cs_n),
        .sclk     (sclk),
        .sdi      (sdi),
        .sdo      (sdo),
        .sdo_oe_n (sdo_oe_n),
        .sdi_thru (serial_in_passthrough),
        .xf       (xf.engine)
    );

    // ****************************************
    // register bank
    // ****************************************
    always_comb begin
        sqg_nxt = sqg_r;
        if (xf.wr_stb && xf.addr == hook_gain_pkg::SQG_ADDR) begin
            sqg_nxt = xf.wdata & hook_gain_pkg::SQG_WR_MASK;
        end
        xf.rdata = (xf.addr == hook_gain_pkg::SQG_ADDR) ? sqg_r : 8'h00;
        spark_quench_sel_hi = sqg_r[hook_gain_pkg::SQ_HI_BIT];
        spark_quench_sel_lo = sqg_r[hook_gain_pkg::SQ_LO_BIT];
        guarded_clear_en    = sqg_r[hook_gain_pkg::GUARD_BIT];
    end

    // ****************************************
    // release length select
    // ****************************************
    always_comb begin
        sel_fast = 1'b0;
        if (onhook_speed_sel && spark_quench_sel_hi
            && spark_quench_sel_lo) begin
            rel_len = SLOW_CYC;
        end else if (!onhook_speed_sel && onhook_speed_sel_b
                     && !spark_quench_sel_hi
                     && !spark_quench_sel_lo) begin
            rel_len = MID_CYC;
        end else begin
            rel_len  = 18'(hook_gain_pkg::FAST_CYC);
            sel_fast = 1'b1;
        end
    end

    // ****************************************
    // hook state and line controls
    // ****************************************
    always_comb begin
        hk_state_nxt = hk_state_r;
        hold_cnt_nxt = hold_cnt_r;
        loop_on_nxt  = loop_on_r;
        case (hk_state_r)
            hook_gain_pkg::HK_ONHOOK: begin
                loop_on_nxt = 1'b0;
                if (offhook_ctrl) begin
                    hk_state_nxt = hook_gain_pkg::HK_OFFHOOK;
                    loop_on_nxt  = 1'b1;
                end
            end
            hook_gain_pkg::HK_OFFHOOK: begin
                loop_on_nxt = 1'b1;
                if (!offhook_ctrl) begin
                    hk_state_nxt = hook_gain_pkg::HK_RELEASE;
                    hold_cnt_nxt = rel_len - 18'h00001;
                end
            end
            hook_gain_pkg::HK_RELEASE: begin
                if (offhook_ctrl) begin
                    hk_state_nxt = hook_gain_pkg::HK_OFFHOOK;
                end else if (hold_cnt_r == 18'h00000) begin
                    hk_state_nxt = hook_gain_pkg::HK_ONHOOK;
                    loop_on_nxt  = 1'b0;
                end else begin
                    hold_cnt_nxt = hold_cnt_r - 18'h00001;
                end
            end
            default: begin
                hk_state_nxt = hook_gain_pkg::HK_ONHOOK;
                loop_on_nxt  = 1'b0;
            end
        endcase
        sq_code_nxt = {spark_quench_sel_hi, spark_quench_sel_lo};
        rxg_nxt     = sqg_r[hook_gain_pkg::RXG_BIT] & line_rev_e_ok;
        guard_nxt   = guarded_clear_en & line_current_sel_bit
                      & line_rev_e_ok
                      & (hk_state_r == hook_gain_pkg::HK_ONHOOK);
        sleep_nxt   = sleep_r | sleep_req;
        ring_n_nxt  = ~ring_rect;
        spk_nxt     = irq_mode_sel ? ~irq_req : spk_pwm;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sqg_r      <= hook_gain_pkg::SQG_RESET;
            hk_state_r <= hook_gain_pkg::HK_ONHOOK;
            hold_cnt_r <= 18'h00000;
            loop_on_r  <= 1'b0;
            sq_code_r  <= 2'h0;
            rxg_r      <= 1'b0;
            guard_r    <= 1'b0;
            sleep_r    <= 1'b0;
            ring_n_r   <= 1'b1;
            spk_r      <= 1'b0;
        end else begin
            sqg_r      <= sqg_nxt;
            hk_state_r <= hk_state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            loop_on_r  <= loop_on_nxt;
            sq_code_r  <= sq_code_nxt;
            rxg_r      <= rxg_nxt;
            guard_r    <= guard_nxt;
            sleep_r    <= sleep_nxt;
            ring_n_r   <= ring_n_nxt;
            spk_r      <= spk_nxt;
        end
    end

    assign loop_current_on    = loop_on_r;
    assign spark_quench_code  = sq_code_r;
    assign rx_gain_boost      = rxg_r;
    assign guard_draw_en      = guard_r;
    assign sleeping           = sleep_r;
    assign ring_detect_out_n  = ring_n_r;
    assign speaker_or_irq_out = spk_r;

    // ****************************************
    // checks
    // ****************************************
    sequence s_rel_start;
        hk_state_r == hook_gain_pkg::HK_OFFHOOK && !offhook_ctrl;
    endsequence

    property p_fast_release;
        @(posedge sys_clk) disable iff (!resetn)
        s_rel_start ##0 sel_fast ##1 !offhook_ctrl |=> !loop_current_on;
    endproperty
    a_fast_release: assert property (p_fast_release)
        else $error("fast release did not end loop current in time");

    property p_load_len;
        @(posedge sys_clk) disable iff (!resetn)
        s_rel_start |=> hold_cnt_r == $past(rel_len) - 18'h00001;
    endproperty
    a_load_len: assert property (p_load_len)
        else $error("release counter loaded with wrong length");

    property p_hold_on;
        @(posedge sys_clk) disable iff (!resetn)
        hk_state_r == hook_gain_pkg::HK_RELEASE && hold_cnt_r != 18'h00000
        && !offhook_ctrl |=> loop_current_on
        && hold_cnt_r == $past(hold_cnt_r) - 18'h00001;
    endproperty
    a_hold_on: assert property (p_hold_on)
        else $error("loop current dropped before release time");

    property p_rsvd_zero;
        @(posedge sys_clk) disable iff (!resetn)
        xf.wr_stb && xf.addr == hook_gain_pkg::SQG_ADDR
        |=> (sqg_r & ~hook_gain_pkg::SQG_WR_MASK) == 8'h00
        && sqg_r == ($past(xf.wdata) & hook_gain_pkg::SQG_WR_MASK);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("register write stored wrong value");

    property p_gain_rev;
        @(posedge sys_clk) disable iff (!resetn)
        rx_gain_boost == ($past(line_rev_e_ok)
        && $past(sqg_r[hook_gain_pkg::RXG_BIT]));
    endproperty
    a_gain_rev: assert property (p_gain_rev)
        else $error("receive gain active without cause");

    property p_guard;
        @(posedge sys_clk) disable iff (!resetn)
        guarded_clear_en && line_current_sel_bit && line_rev_e_ok
        && hk_state_r == hook_gain_pkg::HK_ONHOOK |=> guard_draw_en;
    endproperty
    a_guard: assert property (p_guard)
        else $error("guarded clear draw not enabled");

    property p_reset;
        @(posedge sys_clk)
        !resetn |=> sqg_r == hook_gain_pkg::SQG_RESET && !sleeping
        && !loop_current_on;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not restore control state");

    property p_ring;
        @(posedge sys_clk) disable iff (!resetn)
        ring_rect ##1 1'b1 |-> !ring_detect_out_n;
    endproperty
    a_ring: assert property (p_ring)
        else $error("ring detect not asserted low");

    property p_irq_pin;
        @(posedge sys_clk) disable iff (!resetn)
        irq_mode_sel && irq_req |=> !speaker_or_irq_out;
    endproperty
    a_irq_pin: assert property (p_irq_pin)
        else $error("interrupt not shown on shared pin");
endmodule

// ---- core/serial_port_engine.sv ----
// serial control port: frame decode, read shift-out, write strobe
`timescale 1ns/1ns
module serial_port_engine (
    input  wire logic   sys_clk,
    input  wire logic   resetn,
    input  wire logic   cs_n,
    input  wire logic   sclk,
    input  wire logic   sdi,
    output logic        sdo,
    output logic        sdo_oe_n,
    output logic        sdi_thru,
    spi_xfer_if.engine  xf
);
    hook_gain_pkg::xfer_state_t st_r, st_nxt;
    logic       sclk_q_r, sclk_q_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic       rd_r, rd_nxt;
    logic       load_r, load_nxt;
    logic [7:0] out_r, out_nxt;
    logic       sdo_r, sdo_nxt;
    logic       oe_n_r, oe_n_nxt;
    logic       thru_r, thru_nxt;
    logic       wr_r, wr_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic       rise, fall;
    logic [7:0] byte_in;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        rise       = sclk & ~sclk_q_r;
        fall       = ~sclk & sclk_q_r;
        byte_in    = {sh_r[6:0], sdi};
        st_nxt     = st_r;
        sclk_q_nxt = sclk;
        cnt_nxt    = cnt_r;
        sh_nxt     = sh_r;
        rd_nxt     = rd_r;
        load_nxt   = 1'b0;
        out_nxt    = out_r;
        sdo_nxt    = sdo_r;
        oe_n_nxt   = cs_n;
        thru_nxt   = sdi;
        wr_nxt     = 1'b0;
        addr_nxt   = addr_r;
        wdata_nxt  = wdata_r;
        if (cs_n) begin
            st_nxt  = hook_gain_pkg::XF_IDLE;
            cnt_nxt = 5'h00;
        end else begin
            case (st_r)
                hook_gain_pkg::XF_IDLE: begin
                    st_nxt  = hook_gain_pkg::XF_SHIFT;
                    cnt_nxt = 5'h00;
                end
                hook_gain_pkg::XF_SHIFT: begin
                    if (rise) begin
                        sh_nxt  = byte_in;
                        cnt_nxt = cnt_r + 5'h01;
                        if (cnt_r == hook_gain_pkg::CMD_END) begin
                            rd_nxt = byte_in[hook_gain_pkg::CMD_RD_BIT];
                        end
                        if (cnt_r == hook_gain_pkg::ADDR_END) begin
                            addr_nxt = byte_in;
                            load_nxt = rd_r;
                        end
                        if (cnt_r == hook_gain_pkg::DATA_END) begin
                            st_nxt    = hook_gain_pkg::XF_DONE;
                            wr_nxt    = ~rd_r;
                            wdata_nxt = byte_in;
                        end
                    end
                    if (load_r) begin
                        out_nxt = xf.rdata;
                    end else if (fall && rd_r
                                 && cnt_r > hook_gain_pkg::ADDR_END) begin
                        sdo_nxt = out_r[7];
                        out_nxt = {out_r[6:0], 1'b0};
                    end
                end
                hook_gain_pkg::XF_DONE: begin
                    st_nxt = hook_gain_pkg::XF_DONE;
                end
                default: begin
                    st_nxt = hook_gain_pkg::XF_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_r     <= hook_gain_pkg::XF_IDLE;
            sclk_q_r <= 1'b0;
            cnt_r    <= 5'h00;
            sh_r     <= 8'h00;
            rd_r     <= 1'b0;
            load_r   <= 1'b0;
            out_r    <= 8'h00;
            sdo_r    <= 1'b0;
            oe_n_r   <= 1'b1;
            thru_r   <= 1'b0;
            wr_r     <= 1'b0;
            addr_r   <= 8'h00;
            wdata_r  <= 8'h00;
        end else begin
            st_r     <= st_nxt;
            sclk_q_r <= sclk_q_nxt;
            cnt_r    <= cnt_nxt;
            sh_r     <= sh_nxt;
            rd_r     <= rd_nxt;
            load_r   <= load_nxt;
            out_r    <= out_nxt;
            sdo_r    <= sdo_nxt;
            oe_n_r   <= oe_n_nxt;
            thru_r   <= thru_nxt;
            wr_r     <= wr_nxt;
            addr_r   <= addr_nxt;
            wdata_r  <= wdata_nxt;
        end
    end

    assign sdo       = sdo_r;
    assign sdo_oe_n  = oe_n_r;
    assign sdi_thru  = thru_r;
    assign xf.wr_stb = wr_r;
    assign xf.addr   = addr_r;
    assign xf.wdata  = wdata_r;

    // ****************************************
    // checks
    // ****************************************
    property p_sdo_hiz;
        @(posedge sys_clk) disable iff (!resetn)
        cs_n |=> sdo_oe_n;
    endproperty
    a_sdo_hiz: assert property (p_sdo_hiz)
        else $error("sdo driven while chip select inactive");

    property p_no_wr_idle;
        @(posedge sys_clk) disable iff (!resetn)
        cs_n ##1 cs_n |=> !xf.wr_stb;
    endproperty
    a_no_wr_idle: assert property (p_no_wr_idle)
        else $error("write strobe while chip select inactive");
endmodule

// ---- core/spi_xfer_if.sv ----
// register access strobes between serial engine and register bank
`timescale 1ns/1ns
interface spi_xfer_if;
    logic       wr_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport engine (output wr_stb, output addr, output wdata, input rdata);
    modport regs   (input wr_stb, input addr, input wdata, output rdata);
endinterface
